// ### hw/sopd_pkg.sv
// shared constants, field layout and carrier types for the output post-divider
// assumes a byte-wide register port and one synthesizer-rate core clock
package sopd_pkg;

    // register port geometry
    localparam int unsigned SOPD_ADDR_W = 12;
    localparam int unsigned SOPD_DATA_W = 8;
    localparam int unsigned SOPD_CTRL_W = 24;
    localparam int unsigned SOPD_RATE_W = 16;

    // control word spans three byte addresses, most significant byte first
    localparam logic [SOPD_ADDR_W-1:0] SOPD_ADDR_CTRL_HI = 12'h203;
    localparam logic [SOPD_ADDR_W-1:0] SOPD_ADDR_CTRL_MID = 12'h204;
    localparam logic [SOPD_ADDR_W-1:0] SOPD_ADDR_CTRL_LO = 12'h205;
    localparam logic [SOPD_ADDR_W-1:0] SOPD_ADDR_STATUS = 12'h20C;

    // byte lane positions within the control word
    localparam int unsigned SOPD_LANE_HI_LSB = 16;
    localparam int unsigned SOPD_LANE_MID_LSB = 8;
    localparam int unsigned SOPD_LANE_LO_LSB = 0;

    localparam logic [SOPD_CTRL_W-1:0] SOPD_CTRL_RESET = 24'h000002;

    // field codes
    localparam logic [3:0] SOPD_MODE_FRAME = 4'hF;
    localparam logic [1:0] SOPD_SEL_CLK_A = 2'h0;
    localparam logic [1:0] SOPD_SEL_LOWFREQ = 2'h1;
    localparam logic [1:0] SOPD_SEL_CLK_C = 2'h2;
    localparam logic [1:0] SOPD_SEL_CLK_D = 2'h3;
    localparam logic SOPD_TYPE_CENTRED = 1'b0;
    localparam logic SOPD_POL_NEGATIVE = 1'b1;

    // smallest ratio a single-edge divider can honour
    localparam logic [SOPD_CTRL_W-1:0] SOPD_DIV_MIN = 24'h000002;
    localparam logic [SOPD_CTRL_W-1:0] SOPD_DIV_ONE = 24'h000001;
    localparam logic [SOPD_RATE_W-1:0] SOPD_RATE_ONE = 16'h0001;
    localparam logic [SOPD_RATE_W-1:0] SOPD_RATE_ZERO = 16'h0000;

    // status byte bit positions
    localparam int unsigned SOPD_STAT_LEVEL = 0;
    localparam int unsigned SOPD_STAT_FRAME = 1;
    localparam int unsigned SOPD_STAT_LOWFREQ = 2;
    localparam int unsigned SOPD_STAT_BOUNDARY = 3;

    // control word, field order equals bit order 23:0
    typedef struct packed {
        logic [3:0] mode;
        logic fp_type;
        logic fp_pol;
        logic [1:0] ref_sel;
        logic [SOPD_RATE_W-1:0] rate;
    } sopd_ctrl_t;

    typedef struct packed {
        logic [SOPD_ADDR_W-1:0] addr;
        logic [SOPD_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sopd_reg_req_t;

    typedef struct packed {
        logic clk_a;
        logic clk_c;
        logic clk_d;
    } sopd_sib_clk_t;

    typedef enum logic [1:0] {
        SOPD_OUT_DIV,
        SOPD_OUT_LOWFREQ,
        SOPD_OUT_FRAME
    } sopd_out_kind_t;

    function automatic sopd_out_kind_t sopd_decode(input sopd_ctrl_t c);
        sopd_out_kind_t k;
        if (c.mode != SOPD_MODE_FRAME) begin
            k = SOPD_OUT_DIV;
        end else if (c.ref_sel == SOPD_SEL_LOWFREQ) begin
            k = SOPD_OUT_LOWFREQ;
        end else begin
            k = SOPD_OUT_FRAME;
        end
        return k;
    endfunction : sopd_decode

endpackage : sopd_pkg

// ### hw/sopd_clk_div.sv
// 24-bit ratio divider giving a near-50% duty clock level
// assumes tick is a one-cycle advance strobe on core_clk
`timescale 1ns/100ps
module sopd_clk_div (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // control
    input wire logic restart,
    input wire logic tick,
    input wire logic [sopd_pkg::SOPD_CTRL_W-1:0] div,
    // output
    output logic clk_out
);
    import sopd_pkg::*;

    typedef struct packed {
        logic [SOPD_CTRL_W-1:0] cnt;
        logic level;
    } sopd_div_state_t;

    sopd_div_state_t st_q;
    sopd_div_state_t st_d;
    logic [SOPD_CTRL_W-1:0] ratio;
    logic [SOPD_CTRL_W-1:0] last;
    logic [SOPD_CTRL_W-1:0] half;
    logic [SOPD_CTRL_W-1:0] nxt;

    always_comb begin
        // ratios below two cannot be made on one edge; they run as two
        ratio = (div < SOPD_DIV_MIN) ? SOPD_DIV_MIN : div;
        last = ratio - SOPD_DIV_ONE;
        // odd ratios: high phase is one tick longer
        half = {1'b0, ratio[SOPD_CTRL_W-1:1]} + {{(SOPD_CTRL_W-1){1'b0}}, ratio[0]};
        nxt = (st_q.cnt >= last) ? '0 : st_q.cnt + SOPD_DIV_ONE;
        st_d = st_q;
        if (restart) begin
            st_d.cnt = '0;
            st_d.level = 1'b1;
        end else if (tick) begin
            st_d.cnt = nxt;
            st_d.level = (nxt < half);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign clk_out = st_q.level;

endmodule : sopd_clk_div

// ### hw/sopd_frame_gen.sv
// frame pulse generator counting periods of a selected sibling clock
// assumes ref_clk is a level synchronous to core_clk, slower than core_clk / 2
`timescale 1ns/100ps
module sopd_frame_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // control
    input wire logic restart,
    input wire logic ref_clk,
    input wire logic [sopd_pkg::SOPD_RATE_W-1:0] rate,
    input wire logic fp_type,
    // output, active high before polarity
    output logic pulse,
    output logic boundary
);
    import sopd_pkg::*;

    typedef struct packed {
        logic ref_prev;
        logic [SOPD_RATE_W-1:0] cnt;
        logic pulse;
        logic boundary;
    } sopd_fp_state_t;

    sopd_fp_state_t st_q;
    sopd_fp_state_t st_d;
    logic rise;
    logic fall;
    logic [SOPD_RATE_W-1:0] last;
    logic [SOPD_RATE_W-1:0] nxt;

    always_comb begin
        rise = ref_clk & ~st_q.ref_prev;
        fall = ~ref_clk & st_q.ref_prev;
        // a spacing of zero behaves as one period
        last = (rate == SOPD_RATE_ZERO) ? SOPD_RATE_ZERO : rate - SOPD_RATE_ONE;
        nxt = (st_q.cnt >= last) ? SOPD_RATE_ZERO : st_q.cnt + SOPD_RATE_ONE;
        st_d = st_q;
        st_d.ref_prev = ref_clk;
        st_d.boundary = 1'b0;
        if (restart) begin
            // first rising edge after a change becomes a boundary
            st_d.cnt = last;
            st_d.pulse = 1'b0;
        end else if (rise) begin
            st_d.cnt = nxt;
            st_d.boundary = (nxt == SOPD_RATE_ZERO);
            if (fp_type != SOPD_TYPE_CENTRED) begin
                // pulse opens on the boundary edge, one period wide
                st_d.pulse = (nxt == SOPD_RATE_ZERO);
            end
        end else if (fall && fp_type == SOPD_TYPE_CENTRED) begin
            // half a period either side of the boundary edge
            st_d.pulse = (st_q.cnt == last);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse = st_q.pulse;
    assign boundary = st_q.boundary;

endmodule : sopd_frame_gen

// ### hw/sopd_top.sv
// output post-divider B: control register, divider and frame pulse path
// assumes core_clk is the synthesizer clock, base_tick pulses at twice the
// base frequency, and sibling divider clocks arrive as synchronous levels
`timescale 1ns/100ps
module sopd_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire sopd_pkg::sopd_reg_req_t reg_req,
    output logic [sopd_pkg::SOPD_DATA_W-1:0] reg_rdata,
    // reference sources
    input wire logic base_tick,
    input wire sopd_pkg::sopd_sib_clk_t sib_clk,
    // divided output
    output logic out_clk
);
    import sopd_pkg::*;

    typedef struct packed {
        sopd_ctrl_t ctrl;
        logic [SOPD_DATA_W-1:0] rdata;
        logic out;
        logic restart;
        logic seen_boundary;
    } sopd_top_state_t;

    sopd_top_state_t st_q;
    sopd_top_state_t st_d;
    sopd_out_kind_t kind;
    logic [SOPD_CTRL_W-1:0] ctrl_word;
    // separate copy for the write path, so each comb process owns its own word
    logic [SOPD_CTRL_W-1:0] upd_word;
    logic [SOPD_CTRL_W-1:0] div_ratio;
    logic div_tick;
    logic div_clk;
    logic ref_clk;
    logic fp_pulse;
    logic fp_boundary;
    logic [SOPD_DATA_W-1:0] status;

    // source and ratio selection
    always_comb begin
        kind = sopd_decode(st_q.ctrl);
        ctrl_word = st_q.ctrl;
        if (kind == SOPD_OUT_LOWFREQ) begin
            // slow clock advances on base-rate ticks, ratio is bits 15:0
            div_tick = base_tick;
            div_ratio = {{(SOPD_CTRL_W-SOPD_RATE_W){1'b0}}, st_q.ctrl.rate};
        end else begin
            div_tick = 1'b1;
            // whole word, frame fields included, is the ratio here
            div_ratio = ctrl_word;
        end
        case (st_q.ctrl.ref_sel)
            SOPD_SEL_CLK_A: ref_clk = sib_clk.clk_a;
            SOPD_SEL_CLK_C: ref_clk = sib_clk.clk_c;
            SOPD_SEL_CLK_D: ref_clk = sib_clk.clk_d;
            default: ref_clk = 1'b0;
        endcase
    end

    sopd_clk_div u_div (
        .core_clk(core_clk),
        .srst(srst),
        .restart(st_q.restart),
        .tick(div_tick),
        .div(div_ratio),
        .clk_out(div_clk)
    );

    sopd_frame_gen u_frame (
        .core_clk(core_clk),
        .srst(srst),
        .restart(st_q.restart),
        .ref_clk(ref_clk),
        .rate(st_q.ctrl.rate),
        .fp_type(st_q.ctrl.fp_type),
        .pulse(fp_pulse),
        .boundary(fp_boundary)
    );

    always_comb begin
        status = '0;
        status[SOPD_STAT_LEVEL] = st_q.out;
        status[SOPD_STAT_FRAME] = (kind == SOPD_OUT_FRAME);
        status[SOPD_STAT_LOWFREQ] = (kind == SOPD_OUT_LOWFREQ);
        status[SOPD_STAT_BOUNDARY] = st_q.seen_boundary;
    end

    // register port, output mux
    always_comb begin
        upd_word = st_q.ctrl;
        st_d = st_q;
        st_d.restart = 1'b0;
        st_d.rdata = '0;
        // a byte write changes the mode at once; counters restart from it
        if (reg_req.wr) begin
            case (reg_req.addr)
                SOPD_ADDR_CTRL_HI: begin
                    upd_word[SOPD_LANE_HI_LSB +: SOPD_DATA_W] = reg_req.wdata;
                    st_d.ctrl = upd_word;
                    st_d.restart = 1'b1;
                end
                SOPD_ADDR_CTRL_MID: begin
                    upd_word[SOPD_LANE_MID_LSB +: SOPD_DATA_W] = reg_req.wdata;
                    st_d.ctrl = upd_word;
                    st_d.restart = 1'b1;
                end
                SOPD_ADDR_CTRL_LO: begin
                    upd_word[SOPD_LANE_LO_LSB +: SOPD_DATA_W] = reg_req.wdata;
                    st_d.ctrl = upd_word;
                    st_d.restart = 1'b1;
                end
                default: begin
                    st_d.ctrl = st_q.ctrl;
                end
            endcase
        end
        // boundary flag sticks until a status read; a new boundary wins
        if (reg_req.rd) begin
            case (reg_req.addr)
                SOPD_ADDR_CTRL_HI: st_d.rdata = st_q.ctrl[SOPD_LANE_HI_LSB +: SOPD_DATA_W];
                SOPD_ADDR_CTRL_MID: st_d.rdata = st_q.ctrl[SOPD_LANE_MID_LSB +: SOPD_DATA_W];
                SOPD_ADDR_CTRL_LO: st_d.rdata = st_q.ctrl[SOPD_LANE_LO_LSB +: SOPD_DATA_W];
                SOPD_ADDR_STATUS: begin
                    st_d.rdata = status;
                    st_d.seen_boundary = 1'b0;
                end
                default: st_d.rdata = '0;
            endcase
        end
        if (fp_boundary && kind == SOPD_OUT_FRAME) begin
            st_d.seen_boundary = 1'b1;
        end
        case (kind)
            SOPD_OUT_FRAME: begin
                st_d.out = (st_q.ctrl.fp_pol == SOPD_POL_NEGATIVE) ? ~fp_pulse : fp_pulse;
            end
            SOPD_OUT_LOWFREQ: st_d.out = div_clk;
            SOPD_OUT_DIV: st_d.out = div_clk;
            default: st_d.out = div_clk;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q.ctrl <= SOPD_CTRL_RESET;
            st_q.rdata <= '0;
            st_q.out <= 1'b0;
            st_q.restart <= 1'b1;
            st_q.seen_boundary <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign out_clk = st_q.out;

endmodule : sopd_top

// ### test/sopd_top_chk.sv
// checker for output post-divider B: readback, divider phases, frame pulse timing
// assumes sibling clocks and base tick are synchronous to core_clk
`timescale 1ns/100ps
module sopd_top_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire sopd_pkg::sopd_reg_req_t reg_req,
    input wire logic [sopd_pkg::SOPD_DATA_W-1:0] reg_rdata,
    // references and output
    input wire logic base_tick,
    input wire sopd_pkg::sopd_sib_clk_t sib_clk,
    input wire logic out_clk
);
    import sopd_pkg::*;
    sopd_ctrl_t ctrl_q;
    logic [23:0] len_q;
    logic [3:0] ecnt_q;
    logic [2:0] chg_q;
    logic last_q, ref_q, e1_q, e2_q, ref_lvl, chg, frm;
    logic [24:0] neff;
    logic [7:0] rd_byte;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    always_comb begin
        neff = {1'b0, (ctrl_q[23:0] < SOPD_DIV_MIN) ? SOPD_DIV_MIN : ctrl_q[23:0]};
        case (ctrl_q.ref_sel)
            SOPD_SEL_CLK_C: ref_lvl = sib_clk.clk_c;
            SOPD_SEL_CLK_D: ref_lvl = sib_clk.clk_d;
            default: ref_lvl = sib_clk.clk_a;
        endcase
        case (reg_req.addr)
            SOPD_ADDR_CTRL_HI: rd_byte = ctrl_q[23:16];
            SOPD_ADDR_CTRL_MID: rd_byte = ctrl_q[15:8];
            SOPD_ADDR_CTRL_LO: rd_byte = ctrl_q[7:0];
            default: rd_byte = 8'h00;
        endcase
        chg = out_clk != last_q;
        frm = ctrl_q.mode == SOPD_MODE_FRAME && ctrl_q.ref_sel != SOPD_SEL_LOWFREQ;
    end

    // shadow word, run length, ref edges delayed to line up with out_clk
    always_ff @(posedge core_clk) begin
        last_q <= out_clk;
        ref_q <= ref_lvl;
        e1_q <= ctrl_q.fp_type ? (ref_lvl & ~ref_q) : (ref_q & ~ref_lvl);
        e2_q <= e1_q;
        len_q <= chg ? 24'h000001 : len_q + 24'h000001;
        ecnt_q <= chg ? 4'h0 : ecnt_q + {3'h0, e2_q};
        if (srst) begin
            ctrl_q <= SOPD_CTRL_RESET;
            chg_q <= 3'h0;
        end else if (reg_req.wr) begin
            chg_q <= 3'h0;
            case (reg_req.addr)
                SOPD_ADDR_CTRL_HI: ctrl_q[23:16] <= reg_req.wdata;
                SOPD_ADDR_CTRL_MID: ctrl_q[15:8] <= reg_req.wdata;
                SOPD_ADDR_CTRL_LO: ctrl_q[7:0] <= reg_req.wdata;
                default: ;
            endcase
        end else if (chg && chg_q != 3'h7) begin
            chg_q <= chg_q + 3'h1;
        end
    end

    property p_rd_data;
        reg_req.rd && reg_req.addr != SOPD_ADDR_STATUS |=> reg_rdata == $past(rd_byte);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read byte wrong");
    property p_rd_idle;
        !reg_req.rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_div_hi;
        $fell(out_clk) && chg_q > 3'h3 && ctrl_q.mode != SOPD_MODE_FRAME
            |-> len_q == neff[24:1] + neff[0];
    endproperty
    a_div_hi: assert property (p_div_hi) else $error("high phase length wrong");
    property p_div_lo;
        $rose(out_clk) && chg_q > 3'h3 && ctrl_q.mode != SOPD_MODE_FRAME |-> len_q == neff[24:1];
    endproperty
    a_div_lo: assert property (p_div_lo) else $error("low phase length wrong");
    property p_slow;
        chg && chg_q > 3'h1 && ctrl_q.mode == SOPD_MODE_FRAME && ctrl_q.ref_sel == SOPD_SEL_LOWFREQ
            |-> $past(base_tick) || $past(base_tick, 2) || $past(base_tick, 3);
    endproperty
    a_slow: assert property (p_slow) else $error("slow clock moved without tick");
    property p_fp_edge;
        frm && chg && chg_q > 3'h2 |-> e2_q;
    endproperty
    a_fp_edge: assert property (p_fp_edge) else $error("pulse edge off reference");
    property p_fp_width;
        frm && chg && chg_q > 3'h3 && last_q != ctrl_q.fp_pol |-> ecnt_q == 4'h0;
    endproperty
    a_fp_width: assert property (p_fp_width) else $error("pulse width wrong");
    property p_fp_space;
        frm && chg && chg_q > 3'h3 && last_q == ctrl_q.fp_pol && ctrl_q.rate > 16'h0001
            |-> ecnt_q == ctrl_q.rate - 16'h0002;
    endproperty
    a_fp_space: assert property (p_fp_space) else $error("pulse spacing wrong");
    property p_fp_pol;
        frm && chg && chg_q > 3'h3 && ecnt_q != 4'h0 |-> last_q == ctrl_q.fp_pol;
    endproperty
    a_fp_pol: assert property (p_fp_pol) else $error("pulse idle level wrong");
    c_frame: cover property (frm && chg && chg_q > 3'h3);
    c_slow: cover property (chg && ctrl_q.ref_sel == SOPD_SEL_LOWFREQ && chg_q > 3'h1);
    c_div: cover property ($fell(out_clk) && chg_q > 3'h3 && !frm);
endmodule : sopd_top_chk

bind sopd_top sopd_top_chk u_chk (.core_clk(core_clk), .srst(srst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .base_tick(base_tick), .sib_clk(sib_clk), .out_clk(out_clk));

// ### test/sopd_top_tb_top.sv
// testbench for output post-divider B: registers, divider, slow clock, frame pulses
// assumes the checker is bound to the design in the same compile
`timescale 1ns/100ps
module sopd_top_tb_top;
    import sopd_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    sopd_reg_req_t req = '0;
    logic [SOPD_DATA_W-1:0] rdata;
    logic base_tick = 1'b0;
    sopd_sib_clk_t sib = '0;
    logic out_clk;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    sopd_top DUT (.core_clk(core_clk), .srst(srst), .reg_req(req), .reg_rdata(rdata),
        .base_tick(base_tick), .sib_clk(sib), .out_clk(out_clk));

    always #25 core_clk = ~core_clk;

    // siblings of 8, 6 and 10 cycles, tick every third cycle
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        sib.clk_a <= (cyc % 8) < 4;
        sib.clk_c <= (cyc % 6) < 3;
        sib.clk_d <= (cyc % 10) < 5;
        base_tick <= (cyc % 3) == 0;
    end

    task automatic end_sim;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic wr_word(input logic [23:0] w);
        wr(SOPD_ADDR_CTRL_HI, w[23:16]);
        wr(SOPD_ADDR_CTRL_MID, w[15:8]);
        wr(SOPD_ADDR_CTRL_LO, w[7:0]);
    endtask : wr_word

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(negedge core_clk);
        chk({16'h0000, rdata}, {16'h0000, exp});
    endtask : rd_chk

    // skip the run in progress, wait for lvl, count its full length
    task automatic meas(input logic lvl, output int n);
        int t;
        t = 0;
        n = 0;
        @(negedge core_clk);
        for (int p = 0; p < 3; p++) begin
            // bound covers the divide-by-65536 run but keeps a hang short
            while (((out_clk === lvl) ^ (p == 1)) && t < 70000) begin
                @(negedge core_clk);
                t++;
                n += (p == 2);
            end
        end
        if (t >= 70000) begin
            chk(24'h000000, 24'h000001);
            end_sim();
        end
    endtask : meas

    task automatic s_regs;
        rd_chk(SOPD_ADDR_CTRL_HI, 8'h00);
        rd_chk(SOPD_ADDR_CTRL_MID, 8'h00);
        rd_chk(SOPD_ADDR_CTRL_LO, 8'h02);
        wr(12'h2FF, 8'hA5);
        rd_chk(12'h2FF, 8'h00);
    endtask : s_regs

    task automatic s_div;
        int n;
        meas(1'b1, n);
        chk(24'(n), 24'h000001);
        wr_word(24'h000005);
        rd_chk(SOPD_ADDR_CTRL_LO, 8'h05);
        meas(1'b1, n);
        chk(24'(n), 24'h000003);
        meas(1'b0, n);
        chk(24'(n), 24'h000002);
    endtask : s_div

    task automatic s_slow;
        int n;
        wr_word(24'hF10004);
        meas(1'b1, n);
        meas(1'b1, n);
        chk(24'(n), 24'h000006);
        meas(1'b0, n);
        chk(24'(n), 24'h000006);
    endtask : s_slow

    task automatic s_frame;
        logic [1:0] sel;
        int per;
        int n;
        for (int k = 0; k < 12; k++) begin
            sel = (k < 4) ? 2'h0 : (k < 8) ? 2'h2 : 2'h3;
            per = (k < 4) ? 8 : (k < 8) ? 6 : 10;
            wr_word({4'hF, k[1], k[0], sel, 16'h0003});
            meas(~k[0], n);
            meas(~k[0], n);
            chk(24'(n), 24'(per));
            meas(k[0], n);
            chk(24'(n), 24'(2 * per));
        end
    endtask : s_frame

    // bits 19..16 as ratio: divide by 65536
    task automatic s_wide;
        int n;
        wr_word(24'h010000);
        rd_chk(SOPD_ADDR_CTRL_HI, 8'h01);
        // boundary flag left over from the frame runs, then cleared by the read
        rd_chk(SOPD_ADDR_STATUS, 8'h09);
        rd_chk(SOPD_ADDR_STATUS, 8'h01);
        meas(1'b0, n);
        chk(24'(n), 24'h008000);
    endtask : s_wide

    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        s_regs();
        s_div();
        s_slow();
        s_frame();
        s_wide();
        end_sim();
    end
endmodule : sopd_top_tb_top
